// *** design/tsl_limits.sv ***
// Purpose: Configuration, threshold and NVM unlock registers of a temperature sensor.
// Assumes: Link side runs on lclk; sensor logic on mclk; rst_n is power-on reset.
// Notes: One request outstanding on the link; a toggle handshake crosses it.
// Behaviour
// (R01) Writing soft reset bit starts a 2 ms internal reset; bit reads 0.
// (R02) Marked configuration fields storable in NVM; factory value 0220h.
// (R03) Mode upper bit never stored; startup mode only shutdown or continuous.
// (R04) Cycle codes 0-7 give 15.5,125,250,500 ms,1,4,8,16 s periods.
// (R05) Period never shorter than averaging time: 125 ms, 500 ms, 1 s.
// (R06) Averaging longer than period leaves no standby between groups.
// (R07) Upper threshold: 16-bit read/write two's complement, compared with result.
// (R08) Upper threshold loaded from NVM after power-up or reset; factory 6000h.
// (R09) Lower threshold: 16-bit read/write, result format, compared with result.
// (R10) Lower threshold loaded from NVM after power-up or reset; factory 8000h.
// (R11) Unlock bit clear: writes update logic registers only, NVM untouched.
// (R12) Unlock bit set: writes to programmable registers also program NVM.
// (R13) Unlock register busy bit 14 mirrors configuration busy bit 12.
// (R14) Busy reads 1 during programming or reset load, else 0.
// (R15) Host waits for busy clear before next NVM command.
// (R16) Unlock register resets to 0000h; bits 13 to 0 read zero.
// (R17) Mode 00 continuous, 01 shutdown, 10 continuous reading 00, 11 one-shot.
// (R18) Averaging 00 none, 01 8, 10 32, 11 64 block conversions.
// (R19) Writes to read-only or unused bits ignored; they read defined values.
`timescale 1ns/100ps
module tsl_limits
	import tsl_pkg::*;
#(
	parameter int CYC_PER_US = CLK_MHZ,
	parameter int SRST_CYC = SRST_US * CLK_MHZ,
	parameter int PROG_CYC = PROG_CYC_DEF
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic lclk,
	input wire logic lnk_wr_en,
	input wire logic lnk_rd_en,
	input wire logic [7:0] lnk_addr,
	input wire logic [15:0] lnk_wdata,
	output logic lnk_ready,
	output logic lnk_done,
	output logic [15:0] lnk_rdata,
	output tsl_cfg_t cfg,
	output logic [15:0] upper_thr,
	output logic [15:0] lower_thr,
	output logic nvm_busy,
	output logic srst_active,
	output logic conv_start
);
	tsl_state_t state;
	tsl_state_t next_state;
	tsl_req_t req_hold;
	logic req_tgl, req_s1, req_s2, req_s3, req_pulse;
	logic ack_tgl, ack_s1, ack_s2, ack_s3;
	logic [15:0] rsp_data;
	logic unlock;
	logic [1:0] load_idx;
	logic [31:0] cnt;
	logic [31:0] tmr;
	logic [31:0] period_cyc;
	logic nvm_we;
	logic [1:0] nvm_waddr;
	logic [15:0] nvm_wdata;
	logic [15:0] nvm_rdata;
	logic [15:0] cfg_word;
	logic [15:0] unlock_word;
	logic [15:0] rd_word;
	logic run_ok;
	logic wr_hit;
	logic prog_hit;
	logic [1:0] prog_idx;

	// ----------------------------------------
	// Link side request and answer
	// ----------------------------------------
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ack_s3 <= 1'b0;
		end else begin
			ack_s1 <= ack_tgl;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
		end
	end

	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			req_hold <= '0;
			req_tgl <= 1'b0;
			lnk_ready <= 1'b1;
			lnk_done <= 1'b0;
			lnk_rdata <= '0;
		end else begin
			lnk_done <= 1'b0;
			if (ack_s2 ^ ack_s3) begin
				// Answer word held steady by the system side until next request
				lnk_rdata <= rsp_data;
				lnk_done <= 1'b1;
				lnk_ready <= 1'b1;
			end else if (lnk_ready && (lnk_wr_en || lnk_rd_en)) begin
				req_hold <= '{wr: lnk_wr_en, addr: lnk_addr, data: lnk_wdata};
				req_tgl <= ~req_tgl;
				lnk_ready <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Request crossing into system clock
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else begin
			req_s1 <= req_tgl;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	assign req_pulse = req_s2 ^ req_s3;
	assign wr_hit = req_pulse && req_hold.wr;
	// Soft-reset write wins; it never programs the store
	assign prog_hit = wr_hit && unlock && state == ST_IDLE &&
		req_hold.addr inside {ADDR_CFG, ADDR_UPPER, ADDR_LOWER} &&
		!(req_hold.addr == ADDR_CFG && req_hold.data[BIT_SRST]); // [R12] [R15]
	assign prog_idx = req_hold.addr[1:0] - 2'h1;
	assign run_ok = state inside {ST_IDLE, ST_PROG};

	// ----------------------------------------
	// Read words
	// ----------------------------------------
	assign cfg_word = {3'b000, nvm_busy, cfg, 2'b00}; // [R01] [R19]
	assign unlock_word = {unlock, nvm_busy, 14'h0000}; // [R13] [R16]

	always_comb begin
		unique case (req_hold.addr)
			ADDR_CFG: rd_word = cfg_word;
			ADDR_UPPER: rd_word = upper_thr;
			ADDR_LOWER: rd_word = lower_thr;
			ADDR_UNLOCK: rd_word = unlock_word;
			default: rd_word = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_data <= '0;
			ack_tgl <= 1'b0;
		end else if (req_pulse) begin
			rsp_data <= req_hold.wr ? 16'h0000 : rd_word;
			ack_tgl <= ~ack_tgl;
		end
	end

	// ----------------------------------------
	// Load, program and soft reset sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_LOAD: next_state = ST_CAPT;
			ST_CAPT: next_state = (load_idx == NVM_W_LOWER) ? ST_IDLE : ST_LOAD;
			ST_IDLE: next_state = prog_hit ? ST_PROG : ST_IDLE;
			ST_PROG: next_state = (cnt == 32'(PROG_CYC - 1)) ? ST_IDLE : ST_PROG;
			ST_SRST: next_state = (cnt == 32'(SRST_CYC - 1)) ? ST_LOAD : ST_SRST;
		endcase
		if (wr_hit && req_hold.addr == ADDR_CFG && req_hold.data[BIT_SRST]) begin
			next_state = ST_SRST; // [R01]
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_LOAD;
			load_idx <= NVM_W_CFG;
			cnt <= '0;
			nvm_busy <= 1'b1;
			srst_active <= 1'b0;
		end else begin
			state <= next_state;
			nvm_busy <= next_state inside {ST_LOAD, ST_CAPT, ST_PROG}; // [R14]
			srst_active <= next_state == ST_SRST;
			cnt <= (next_state != state) ? 32'h0 : cnt + 32'h1;
			if (state == ST_CAPT) begin
				load_idx <= load_idx + 2'h1;
			end else if (state != ST_LOAD) begin
				load_idx <= NVM_W_CFG;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			nvm_we <= 1'b0;
			nvm_waddr <= '0;
			nvm_wdata <= '0;
		end else begin
			nvm_we <= prog_hit; // [R11] [R12]
			nvm_waddr <= prog_idx;
			// Mode upper bit never reaches the store
			nvm_wdata <= (prog_idx == NVM_W_CFG) ?
				(req_hold.data & NVM_CFG_MASK & ~16'h0800) : req_hold.data; // [R02] [R03]
		end
	end

	tsl_nvm #(
		.W(16),
		.DEPTH(3),
		.AW(2)
	) u_nvm (
		.mclk(mclk),
		.rst_n(rst_n),
		.we(nvm_we),
		.waddr(nvm_waddr),
		.wdata(nvm_wdata),
		.raddr(load_idx),
		.rdata(nvm_rdata)
	);

	// ----------------------------------------
	// Logic registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= tsl_cfg_t'(CFG_FACTORY[11:2]);
			upper_thr <= UPPER_FACTORY;
			lower_thr <= LOWER_FACTORY;
			unlock <= UNLOCK_RESET[BIT_UNLOCK];
		end else if (state == ST_CAPT) begin
			unique case (load_idx)
				NVM_W_CFG: cfg <= tsl_cfg_t'({1'b0, nvm_rdata[10:2]}); // [R03]
				NVM_W_UPPER: upper_thr <= nvm_rdata; // [R08] [R07]
				default: lower_thr <= nvm_rdata; // [R10] [R09]
			endcase
		end else if (state == ST_SRST) begin
			unlock <= UNLOCK_RESET[BIT_UNLOCK]; // [R16]
		end else if (wr_hit) begin
			unique case (req_hold.addr)
				ADDR_CFG: begin
					cfg.mode <= (req_hold.data[11:10] == 2'b10) ?
						2'b00 : req_hold.data[11:10]; // [R17]
					cfg.conv <= req_hold.data[9:CONV_LSB];
					cfg.avg <= req_hold.data[6:AVG_LSB]; // [R18]
					cfg.therm <= req_hold.data[BIT_THERM];
					cfg.pol <= req_hold.data[BIT_POL];
					cfg.dr_sel <= req_hold.data[BIT_DRSEL];
				end
				ADDR_UPPER: upper_thr <= req_hold.data; // [R07] [R11]
				ADDR_LOWER: lower_thr <= req_hold.data; // [R09] [R11]
				ADDR_UNLOCK: unlock <= req_hold.data[BIT_UNLOCK]; // [R19]
				default: ;
			endcase
		end else if (cfg.mode == 2'b11 && run_ok) begin
			// One-shot falls back to shutdown once fired
			cfg.mode <= 2'b01; // [R17]
		end
	end

	// ----------------------------------------
	// Conversion cycle timer
	// ----------------------------------------
	always_comb begin
		int us;
		us = PERIOD_US[cfg.conv]; // [R04]
		if (AVG_MIN_US[cfg.avg] > us) begin
			us = AVG_MIN_US[cfg.avg]; // [R05] [R06]
		end
		period_cyc = 32'(us * CYC_PER_US);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tmr <= '0;
			conv_start <= 1'b0;
		end else begin
			conv_start <= 1'b0;
			if (!run_ok || cfg.mode[0]) begin
				tmr <= '0;
				conv_start <= run_ok && cfg.mode == 2'b11 && !wr_hit; // [R17]
			end else if (tmr >= period_cyc - 32'h1) begin
				// Back-to-back groups when averaging outlasts the period
				tmr <= '0;
				conv_start <= 1'b1; // [R04] [R06]
			end else begin
				tmr <= tmr + 32'h1;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_srst_length: assert property (@(posedge mclk) disable iff (!rst_n) // [R01]
		$fell(srst_active) |-> $past(cnt) == 32'(SRST_CYC - 1))
		else $error("soft reset length wrong");
	a_srst_reads0: assert property (@(posedge mclk) disable iff (!rst_n) // [R01]
		cfg_word[1:0] == 2'b00) else $error("soft reset bit reads nonzero");
	a_mode_select_upper_bit_unstored: assert property (@(posedge mclk) disable iff (!rst_n) // [R03]
		nvm_we && nvm_waddr == NVM_W_CFG |-> nvm_wdata[11] == 1'b0)
		else $error("mode upper bit stored");
	a_period_floor: assert property (@(posedge mclk) disable iff (!rst_n) // [R05]
		run_ok && cfg.mode == 2'b00 && tmr != 32'h0 |-> period_cyc >=
		32'(AVG_MIN_US[cfg.avg] * CYC_PER_US)) else $error("period below averaging");
	a_locked_noprog: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
		wr_hit && !unlock |=> !nvm_we) else $error("locked write programmed");
	a_unlock_prog: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
		prog_hit |=> nvm_we ##1 nvm_busy [*3]) else $error("unlocked write lost");
	a_busy_mirror: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
		cfg_word[12] == unlock_word[14]) else $error("busy mirror differs");
	a_busy_load: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
		state == ST_LOAD |-> ##1 nvm_busy ##1 (nvm_busy || state == ST_IDLE))
		else $error("busy low during load");
	a_unused_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [R16]
		unlock_word[13:0] == 14'h0000 && cfg_word[15:13] == 3'b000)
		else $error("unused bits nonzero");
	a_mode_fold: assert property (@(posedge mclk) disable iff (!rst_n) // [R17]
		cfg.mode != 2'b10) else $error("mode 10 kept");
	a_upper_load: assert property (@(posedge mclk) disable iff (!rst_n) // [R08]
		state == ST_CAPT && load_idx == NVM_W_UPPER |=> upper_thr == $past(nvm_rdata))
		else $error("upper threshold not loaded");
	a_link_done: assert property (@(posedge lclk) disable iff (!rst_n)
		lnk_done |-> lnk_ready) else $error("done without ready");

	c_soft_reset: cover property (@(posedge mclk) disable iff (!rst_n)
		$rose(srst_active));
	c_nvm_prog: cover property (@(posedge mclk) disable iff (!rst_n) nvm_we);
	c_one_shot: cover property (@(posedge mclk) disable iff (!rst_n)
		conv_start && cfg.mode == 2'b11);
	c_cont_tick: cover property (@(posedge mclk) disable iff (!rst_n)
		conv_start && cfg.mode == 2'b00);

endmodule : tsl_limits

// *** design/tsl_nvm.sv ***
// Purpose: Non-volatile word store for configuration and threshold words.
// Assumes: Power-on reset stands for the factory-programmed contents.
// Notes: Read data is registered; one write port, one read port.
`timescale 1ns/100ps
module tsl_nvm
	import tsl_pkg::*;
#(
	parameter int W = 16,
	parameter int DEPTH = 3,
	parameter int AW = 2
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];

	// ----------------------------------------
	// Storage, one word per entry
	// ----------------------------------------
	for (genvar i = 0; i < DEPTH; i++) begin : g_word
		localparam logic [W-1:0] FACT = (i == 0) ? W'(CFG_FACTORY) :
			(i == 1) ? W'(UPPER_FACTORY) : W'(LOWER_FACTORY);
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				mem[i] <= FACT;
			end else if (we && waddr == AW'(i)) begin
				mem[i] <= wdata;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
		end
	end

endmodule : tsl_nvm

// *** inc/tsl_pkg.sv ***
// Purpose: Shared constants and types for the sensor limit and NVM register bank.
// Assumes: 40 MHz system clock; register offsets are word addresses on the link.
// Notes: Times kept in microseconds, programming time in cycles; other cycle counts derived in the top module.
package tsl_pkg;

	// ----------------------------------------
	// Register map and fields
	// ----------------------------------------
	localparam logic [7:0] ADDR_CFG = 8'h01;
	localparam logic [7:0] ADDR_UPPER = 8'h02;
	localparam logic [7:0] ADDR_LOWER = 8'h03;
	localparam logic [7:0] ADDR_UNLOCK = 8'h04;
	localparam logic [15:0] CFG_FACTORY = 16'h0220;
	localparam logic [15:0] UPPER_FACTORY = 16'h6000;
	localparam logic [15:0] LOWER_FACTORY = 16'h8000;
	localparam logic [15:0] UNLOCK_RESET = 16'h0000;
	localparam logic [15:0] NVM_CFG_MASK = 16'h07FC;
	localparam int BIT_UNLOCK = 15;
	localparam int BIT_SRST = 1;
	localparam int MOD_LSB = 10;
	localparam int CONV_LSB = 7;
	localparam int AVG_LSB = 5;
	localparam int BIT_THERM = 4;
	localparam int BIT_POL = 3;
	localparam int BIT_DRSEL = 2;
	localparam logic [1:0] NVM_W_CFG = 2'h0;
	localparam logic [1:0] NVM_W_UPPER = 2'h1;
	localparam logic [1:0] NVM_W_LOWER = 2'h2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int SRST_US = 2000;
	localparam int PROG_CYC_DEF = 200;
	localparam int PERIOD_US [8] = '{15500, 125000, 250000, 500000,
		1000000, 4000000, 8000000, 16000000};
	localparam int AVG_MIN_US [4] = '{0, 125000, 500000, 1000000};

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] conv;
		logic [1:0] avg;
		logic therm;
		logic pol;
		logic dr_sel;
	} tsl_cfg_t;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [15:0] data;
	} tsl_req_t;

	typedef enum logic [2:0] {ST_LOAD, ST_CAPT, ST_IDLE, ST_PROG, ST_SRST} tsl_state_t;

endpackage : tsl_pkg

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for the limit and NVM register bank.
// Assumes: Shortened counts: one cycle per microsecond, short reset and programming.
// Notes: Averaging-limited periods exceed the run budget and are left to assertions.
`timescale 1ns/100ps
module testbench
	import tsl_pkg::*;
;
	logic mclk, lclk, rst_n;
	logic wr_en, rd_en, ready, done, busy, srst, cstart;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, upper, lower;
	tsl_cfg_t cfg;
	int mismatches, n_compared, cycles, n_conv, conv_at, conv_gap, srst_len, busy_len, c;

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		lclk = 1'b0;
		#3;
		forever #6 lclk = ~lclk;
	end

	tsl_limits #(.CYC_PER_US(1), .SRST_CYC(50), .PROG_CYC(8)) DUT (.mclk(mclk), .rst_n(rst_n),
		.lclk(lclk), .lnk_wr_en(wr_en), .lnk_rd_en(rd_en), .lnk_addr(addr),
		.lnk_wdata(wdata), .lnk_ready(ready), .lnk_done(done), .lnk_rdata(rdata),
		.cfg(cfg), .upper_thr(upper), .lower_thr(lower), .nvm_busy(busy),
		.srst_active(srst), .conv_start(cstart));
	tsl_host host (.lclk(lclk), .lnk_ready(ready), .lnk_done(done), .lnk_rdata(rdata),
		.lnk_wr_en(wr_en), .lnk_rd_en(rd_en), .lnk_addr(addr), .lnk_wdata(wdata));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic conclude;
		// Link transfers that never finished count as mismatches
		mismatches += host.n_lost;
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] q;
		host.xfer(1'b0, a, 16'h0000, q);
		chk(q, exp);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		host.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic wait_idle;
		int n;
		n = 0;
		repeat (3) @(posedge mclk);
		#1;
		while (busy !== 1'b0 && n < 500) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 500) mismatches++;
	endtask : wait_idle

	// Soft reset then reload; hold time counted by the monitor
	task automatic soft_reset;
		srst_len = 0;
		wr(ADDR_CFG, 16'h0002);
		repeat (60) @(posedge mclk);
		wait_idle();
	endtask : soft_reset

	// Monitor and hang guard; ceiling covers three of the shortest (15.5 ms) conversion periods
	always @(posedge mclk) begin
		cycles++;
		if (srst === 1'b1) srst_len++;
		if (busy === 1'b1) busy_len++;
		if (cstart === 1'b1) begin
			n_conv++;
			conv_gap = cycles - conv_at;
			conv_at = cycles;
		end
		if (cycles > 60000) begin
			mismatches++;
			conclude();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		chk(upper, UPPER_FACTORY);
		chk(lower, LOWER_FACTORY);
		chk({15'h0000, busy}, 16'h0001);
		rst_n = 1'b1;
		wait_idle();
		rd(ADDR_CFG, CFG_FACTORY);
		rd(ADDR_UPPER, UPPER_FACTORY);
		rd(ADDR_LOWER, LOWER_FACTORY);
		rd(ADDR_UNLOCK, UNLOCK_RESET);
		rd(8'h00, 16'h0000);
		rd(8'h05, 16'h0000);
		wr(ADDR_UPPER, 16'hFF38);
		rd(ADDR_UPPER, 16'hFF38);
		chk(upper, 16'hFF38);
		wr(ADDR_LOWER, 16'h1234);
		rd(ADDR_LOWER, 16'h1234);
		chk(lower, 16'h1234);
		wr(ADDR_CFG, 16'hF421);
		rd(ADDR_CFG, 16'h0420);
		c = n_conv;
		wr(ADDR_CFG, 16'h0C20);
		repeat (4) @(posedge mclk);
		chk(16'(n_conv - c), 16'h0001);
		rd(ADDR_CFG, 16'h0420);
		c = n_conv;
		wr(ADDR_CFG, 16'h0800);
		rd(ADDR_CFG, 16'h0000);
		wait (n_conv >= c + 2);
		chk(16'(conv_gap), 16'd15500);
		soft_reset();
		chk(16'(srst_len), 16'd50);
		rd(ADDR_CFG, CFG_FACTORY);
		rd(ADDR_UPPER, UPPER_FACTORY);
		wr(ADDR_UNLOCK, 16'hFFFF);
		rd(ADDR_UNLOCK, 16'h8000);
		busy_len = 0;
		host.prog(ADDR_UPPER, 16'h1111);
		wait_idle();
		chk(16'(busy_len), 16'd8);
		host.prog(ADDR_CFG, 16'h0C20);
		wait_idle();
		soft_reset();
		chk(16'(srst_len), 16'd50);
		rd(ADDR_CFG, 16'h0420);
		rd(ADDR_UPPER, 16'h1111);
		rd(ADDR_UNLOCK, UNLOCK_RESET);
		conclude();
	end
endmodule : testbench

// *** verif/tsl_host.sv ***
// Purpose: Link-side host model issuing register reads and writes.
// Assumes: One request outstanding; taken at an lclk edge with ready high.
// Notes: Idle address and data lines show the inverse of the last request.
`timescale 1ns/100ps
module tsl_host
	import tsl_pkg::*;
(
	input wire logic lclk,
	input wire logic lnk_ready,
	input wire logic lnk_done,
	input wire logic [15:0] lnk_rdata,
	output logic lnk_wr_en,
	output logic lnk_rd_en,
	output logic [7:0] lnk_addr,
	output logic [15:0] lnk_wdata
);
	int n_lost;

	initial begin
		lnk_wr_en = 1'b0;
		lnk_rd_en = 1'b0;
		lnk_addr = 8'h00;
		lnk_wdata = 16'h0000;
	end

	// ----------------------------------------
	// Transfers
	// ----------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		n = 0;
		@(posedge lclk);
		#1;
		lnk_wr_en = wr;
		lnk_rd_en = !wr;
		lnk_addr = a;
		lnk_wdata = d;
		// Ready looked at settled, request held to the edge that takes it
		while (lnk_ready !== 1'b1 && n < 50) begin
			@(posedge lclk);
			#1;
			n++;
		end
		if (n >= 50) n_lost++;
		@(posedge lclk);
		#1;
		lnk_wr_en = 1'b0;
		lnk_rd_en = 1'b0;
		lnk_addr = ~a;
		lnk_wdata = ~d;
		n = 0;
		while (lnk_done !== 1'b1 && n < 100) begin
			@(posedge lclk);
			#1;
			n++;
		end
		if (n >= 100) n_lost++;
		q = lnk_rdata;
	endtask : xfer

	// Programming write only once the store reports idle
	task automatic prog(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] s;
		s = 16'h4000;
		while (s[14] !== 1'b0) xfer(1'b0, ADDR_UNLOCK, 16'h0000, s);
		xfer(1'b1, a, d, s);
	endtask : prog
endmodule : tsl_host
